// ---- pkg/rac_defs.vh ----
// constants for the region access checker
// assumes inclusion by the checker and its region matcher
`ifndef RAC_DEFS_VH
`define RAC_DEFS_VH
// ==========================================================
// system register indices
`define RAC_IDX_ADDR0      5'h00
`define RAC_IDX_SEL0       5'h08
`define RAC_IDX_PERM_A     5'h10
`define RAC_IDX_PERM_B     5'h11
`define RAC_IDX_CTRL       5'h12
// ==========================================================
// field positions
`define RAC_BASE_MSB       31
`define RAC_BASE_LSB       12
`define RAC_SIZE_MSB       5
`define RAC_SIZE_LSB       1
`define RAC_VALID_BIT      0
`define RAC_EN_BIT         0
// ==========================================================
// sizes and reset values
`define RAC_REGIONS        8
`define RAC_SIZE_MIN       5'h0b
`define RAC_RST_WORD       32'h0000_0000
// ==========================================================
// access kinds
`define RAC_KIND_READ      2'h0
`define RAC_KIND_WRITE     2'h1
`define RAC_KIND_EXEC      2'h2
`endif

// ---- design/rac_region_match.v ----
// one region: address hit and subregion permission source
// assumes region fields come straight from the checker registers
`timescale 1ns/1ps
`default_nettype none
`include "rac_defs.vh"
module rac_region_match (
   // region setup
   input  wire [19:0] base_in,
   input  wire [4:0]  size_in,
   input  wire        valid_in,
   input  wire [15:0] sel_in,
   // access
   input  wire [31:0] addr_in,
   // result
   output wire        hit_out,
   output wire        use_b_out
);
   // ==========================================================
   // match
   wire [4:0]  size_c;
   wire [31:0] mask;
   wire [4:0]  shift;
   wire [31:0] shifted;
   wire [3:0]  sub_idx;
   assign size_c  = (size_in < `RAC_SIZE_MIN) ? `RAC_SIZE_MIN : size_in;
   // bits at or above size+1 are compared
   assign mask    = (size_c == 5'h1f) ? 32'h0000_0000 :
                    ~((32'h0000_0002 << size_c) - 32'h0000_0001);
   assign hit_out = valid_in &&
                    (((addr_in ^ {base_in, 12'h000}) & mask) == 32'h0);
   // ==========================================================
   // subregion: k-th sixteenth from base
   assign shift     = size_c - 5'h03;
   assign shifted   = addr_in >> shift;
   assign sub_idx   = shifted[3:0];
   assign use_b_out = sel_in[sub_idx];
endmodule
`default_nettype wire

// ---- design/rac_checker.v ----
// region access checker for fetch and data accesses
// assumes core aborts on any violation flag and stacks stack_pc_out
//
// Contract
// - both permission registers reset to zero
// - each permission register holds a 4-bit code per region
// - codes 0-3 grant privileged R, RX, RW, RWX; unprivileged nothing
// - codes 4-7 grant R, RX, RW, RWX in both modes
// - 8 is priv RW unpriv R; 9 is priv RW unpriv RX
// - code 10 denies all; higher codes undefined, here denied
// - enable set checks every access; clear raises nothing
// - bad fetch raises instruction protection fault, stacks its address unless a data fault in the same cycle stacks dc_pc_in
// - bad data access raises data protection fault, stacks its instruction pc
// - fetch hitting no region raises instruction miss fault
// - data access hitting no region raises data miss fault
// - access hitting several regions raises multiple-hit fault
// - subregion k is the k-th sixteenth of the region
// - select bit k picks register a or b for subregion k
// - size code 11 is 4 KB, doubling to 31 for 4 GB
// - only valid regions match; valid bits reset to zero
// - enable bit clears on reset
`timescale 1ns/1ps
`default_nettype none
`include "rac_defs.vh"
module rac_checker (
   // clock and reset
   input  wire        clk_in,
   input  wire        reset_in,
   // system register port
   input  wire        sr_we_in,
   input  wire        sr_re_in,
   input  wire [4:0]  sr_addr_in,
   input  wire [31:0] sr_wdata_in,
   output reg  [31:0] sr_rdata_out,
   // instruction side check
   input  wire        if_valid_in,
   input  wire [31:0] if_addr_in,
   input  wire        if_priv_in,
   output reg         if_done_out,
   output reg         if_prot_out,
   output reg         if_miss_out,
   // data side check
   input  wire        dc_valid_in,
   input  wire [31:0] dc_addr_in,
   input  wire        dc_write_in,
   input  wire        dc_priv_in,
   input  wire [31:0] dc_pc_in,
   output reg         dc_done_out,
   output reg         dc_prot_out,
   output reg         dc_miss_out,
   // shared fault report
   output reg         multi_hit_out,
   output reg         abort_out,
   output reg  [31:0] stack_pc_out
);
   // ==========================================================
   // rights decode
   function rac_allow;
      input [3:0] code;
      input       priv;
      input [1:0] kind;
      reg         r;
      reg         w;
      reg         x;
      begin
         r = 1'b0;
         w = 1'b0;
         x = 1'b0;
         case (code)
            4'h0, 4'h1, 4'h2, 4'h3: begin
               r = priv;
               x = priv & code[0];
               w = priv & code[1];
            end
            4'h4, 4'h5, 4'h6, 4'h7: begin
               r = 1'b1;
               x = code[0];
               w = code[1];
            end
            4'h8, 4'h9: begin
               r = 1'b1;
               w = priv;
               x = code[0] & ~priv;
            end
            default: begin
               r = 1'b0;
            end
         endcase
         case (kind)
            `RAC_KIND_READ:  rac_allow = r;
            `RAC_KIND_WRITE: rac_allow = w;
            `RAC_KIND_EXEC:  rac_allow = x;
            default:         rac_allow = 1'b0;
         endcase
      end
   endfunction
   // ==========================================================
   // registers
   reg [31:0] access_perm_a_r;
   reg [31:0] access_perm_b_r;
   reg        enable_r;
   reg [19:0] base_r  [0:`RAC_REGIONS-1];
   reg [4:0]  size_r  [0:`RAC_REGIONS-1];
   reg        valid_r [0:`RAC_REGIONS-1];
   reg [15:0] subregion_select_r [0:`RAC_REGIONS-1];
   wire [`RAC_REGIONS-1:0] if_hit;
   wire [`RAC_REGIONS-1:0] if_ok;
   wire [`RAC_REGIONS-1:0] dc_hit;
   wire [`RAC_REGIONS-1:0] dc_ok;
   wire [1:0] dc_kind;
   assign dc_kind = dc_write_in ? `RAC_KIND_WRITE : `RAC_KIND_READ;
   genvar g;
   generate
      for (g = 0; g < `RAC_REGIONS; g = g + 1) begin : region
         wire       if_b;
         wire       dc_b;
         wire [3:0] if_code;
         wire [3:0] dc_code;
         always @(posedge clk_in) begin
            if (reset_in) begin
               base_r[g]  <= 20'h00000;
               size_r[g]  <= 5'h00;
               valid_r[g] <= 1'b0;
               subregion_select_r[g] <= 16'h0000;
            end else if (sr_we_in) begin
               if (sr_addr_in == `RAC_IDX_ADDR0 + g) begin
                  base_r[g]  <= sr_wdata_in[`RAC_BASE_MSB:`RAC_BASE_LSB];
                  size_r[g]  <= sr_wdata_in[`RAC_SIZE_MSB:`RAC_SIZE_LSB];
                  valid_r[g] <= sr_wdata_in[`RAC_VALID_BIT];
               end
               if (sr_addr_in == `RAC_IDX_SEL0 + g) begin
                  subregion_select_r[g] <= sr_wdata_in[15:0];
               end
            end
         end
         rac_region_match u_if (
            .base_in   (base_r[g]),
            .size_in   (size_r[g]),
            .valid_in  (valid_r[g]),
            .sel_in    (subregion_select_r[g]),
            .addr_in   (if_addr_in),
            .hit_out   (if_hit[g]),
            .use_b_out (if_b)
         );
         rac_region_match u_dc (
            .base_in   (base_r[g]),
            .size_in   (size_r[g]),
            .valid_in  (valid_r[g]),
            .sel_in    (subregion_select_r[g]),
            .addr_in   (dc_addr_in),
            .hit_out   (dc_hit[g]),
            .use_b_out (dc_b)
         );
         // region g uses field g of the chosen register
         assign if_code = if_b ? access_perm_b_r[4*g +: 4] :
                                 access_perm_a_r[4*g +: 4];
         assign dc_code = dc_b ? access_perm_b_r[4*g +: 4] :
                                 access_perm_a_r[4*g +: 4];
         assign if_ok[g] = rac_allow(if_code, if_priv_in,
                                     `RAC_KIND_EXEC);
         assign dc_ok[g] = rac_allow(dc_code, dc_priv_in, dc_kind);
      end
   endgenerate
   // ==========================================================
   // global registers
   always @(posedge clk_in) begin
      if (reset_in) begin
         access_perm_a_r <= `RAC_RST_WORD;
         access_perm_b_r <= `RAC_RST_WORD;
         enable_r        <= 1'b0;
      end else if (sr_we_in) begin
         if (sr_addr_in == `RAC_IDX_PERM_A) begin
            access_perm_a_r <= sr_wdata_in;
         end
         if (sr_addr_in == `RAC_IDX_PERM_B) begin
            access_perm_b_r <= sr_wdata_in;
         end
         if (sr_addr_in == `RAC_IDX_CTRL) begin
            enable_r <= sr_wdata_in[`RAC_EN_BIT];
         end
      end
   end
   // ==========================================================
   // register read
   reg [31:0] rd_nxt;
   wire [2:0] rd_reg;
   assign rd_reg = sr_addr_in[2:0];
   always @* begin
      rd_nxt = 32'h0000_0000;
      if (sr_addr_in < `RAC_IDX_SEL0) begin
         rd_nxt = {base_r[rd_reg], 6'h00, size_r[rd_reg], valid_r[rd_reg]};
      end else if (sr_addr_in < `RAC_IDX_PERM_A) begin
         rd_nxt = {16'h0000, subregion_select_r[rd_reg]};
      end else if (sr_addr_in == `RAC_IDX_PERM_A) begin
         rd_nxt = access_perm_a_r;
      end else if (sr_addr_in == `RAC_IDX_PERM_B) begin
         rd_nxt = access_perm_b_r;
      end else if (sr_addr_in == `RAC_IDX_CTRL) begin
         rd_nxt = {31'h0000_0000, enable_r};
      end
   end
   always @(posedge clk_in) begin
      if (reset_in) begin
         sr_rdata_out <= 32'h0000_0000;
      end else if (sr_re_in) begin
         sr_rdata_out <= rd_nxt;
      end
   end
   // ==========================================================
   // fault decision
   wire if_multi;
   wire dc_multi;
   wire if_miss;
   wire dc_miss;
   wire if_prot;
   wire dc_prot;
   wire if_chk;
   wire dc_chk;
   assign if_chk   = if_valid_in & enable_r;
   assign dc_chk   = dc_valid_in & enable_r;
   assign if_multi = if_chk &
                     ((if_hit & (if_hit - 8'h01)) != 8'h00);
   assign dc_multi = dc_chk & ((dc_hit & (dc_hit - 8'h01)) != 8'h00);
   assign if_miss  = if_chk & (if_hit == 8'h00);
   assign dc_miss  = dc_chk & (dc_hit == 8'h00);
   assign if_prot  = if_chk & ~if_multi & ~if_miss &
                     ((if_hit & if_ok) == 8'h00);
   assign dc_prot  = dc_chk & ~dc_multi & ~dc_miss &
                     ((dc_hit & dc_ok) == 8'h00);
   always @(posedge clk_in) begin
      if (reset_in) begin
         if_done_out   <= 1'b0;
         if_prot_out   <= 1'b0;
         if_miss_out   <= 1'b0;
         dc_done_out   <= 1'b0;
         dc_prot_out   <= 1'b0;
         dc_miss_out   <= 1'b0;
         multi_hit_out <= 1'b0;
         abort_out     <= 1'b0;
         stack_pc_out  <= 32'h0000_0000;
      end else begin
         if_done_out   <= if_valid_in;
         if_prot_out   <= if_prot;
         if_miss_out   <= if_miss;
         dc_done_out   <= dc_valid_in;
         dc_prot_out   <= dc_prot;
         dc_miss_out   <= dc_miss;
         multi_hit_out <= if_multi | dc_multi;
         abort_out     <= if_prot | if_miss | if_multi |
                          dc_prot | dc_miss | dc_multi;
         // data fault has the failing instruction's pc
         if (dc_prot | dc_miss | dc_multi) begin
            stack_pc_out <= dc_pc_in;
         end else if (if_prot | if_miss | if_multi) begin
            stack_pc_out <= if_addr_in;
         end
      end
   end
endmodule
`default_nettype wire

// ---- test/rac_checker_sva.sv ----
// port assertions for the region access checker
// assumes binding onto every rac_checker instance
`timescale 1ns/1ps
`default_nettype none
`include "rac_defs.vh"
module rac_checker_sva (
   // clock and reset
   input wire        clk_in,
   input wire        reset_in,
   // register port
   input wire        sr_we_in,
   input wire [4:0]  sr_addr_in,
   input wire [31:0] sr_wdata_in,
   // requests
   input wire        if_valid_in,
   input wire [31:0] if_addr_in,
   input wire [31:0] dc_pc_in,
   // results
   input wire        if_done_out,
   input wire        if_prot_out,
   input wire        if_miss_out,
   input wire        dc_prot_out,
   input wire        dc_miss_out,
   input wire        multi_hit_out,
   input wire        abort_out,
   input wire [31:0] stack_pc_out
);
   // ==========================================================
   // enable mirror
   logic en_r;
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         en_r <= 1'b0;
      end else if (sr_we_in && sr_addr_in == `RAC_IDX_CTRL) begin
         en_r <= sr_wdata_in[`RAC_EN_BIT];
      end
   end
   // ==========================================================
   // properties
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   property p_off; !en_r |=> !abort_out; endproperty
   property p_rst;
      @(posedge clk_in) disable iff (1'b0) reset_in |=> !abort_out;
   endproperty
   property p_done; if_valid_in |=> if_done_out; endproperty
   property p_idle;
      !if_valid_in |=> !if_done_out && !if_prot_out && !if_miss_out;
   endproperty
   property p_ipc;
      (if_prot_out || if_miss_out) && !dc_prot_out && !dc_miss_out &&
         !multi_hit_out |-> stack_pc_out == $past(if_addr_in);
   endproperty
   property p_dpc;
      dc_prot_out || dc_miss_out |-> stack_pc_out == $past(dc_pc_in);
   endproperty
   property p_imiss; if_miss_out |-> !if_prot_out && abort_out; endproperty
   property p_dmiss; dc_miss_out |-> !dc_prot_out && abort_out; endproperty
   property p_multi; multi_hit_out |-> abort_out; endproperty
   property p_hold; !abort_out |-> $stable(stack_pc_out); endproperty
   a_off: assert property (p_off) else $error("flag while off");
   a_rst: assert property (p_rst) else $error("flag in reset");
   a_done: assert property (p_done) else $error("no done");
   a_idle: assert property (p_idle) else $error("stray result");
   a_ipc: assert property (p_ipc) else $error("fetch pc");
   a_dpc: assert property (p_dpc) else $error("data pc");
   a_imiss: assert property (p_imiss) else $error("fetch miss");
   a_dmiss: assert property (p_dmiss) else $error("data miss");
   a_multi: assert property (p_multi) else $error("multi hit");
   a_hold: assert property (p_hold) else $error("pc moved");
   c_prot: cover property (if_prot_out);
   c_miss: cover property (dc_miss_out);
   c_multi: cover property (multi_hit_out);
endmodule
bind rac_checker rac_checker_sva chk_u (.clk_in, .reset_in, .sr_we_in,
   .sr_addr_in, .sr_wdata_in, .if_valid_in, .if_addr_in, .dc_pc_in,
   .if_done_out, .if_prot_out, .if_miss_out, .dc_prot_out, .dc_miss_out,
   .multi_hit_out, .abort_out, .stack_pc_out);
`default_nettype wire

// ---- test/rac_core_model.sv ----
// core side: takes the trap and stacks the faulting pc
// assumes abort and pc come straight from the checker
`timescale 1ns/1ps
`default_nettype none
module rac_core_model (
   // clock and reset
   input wire         clk_in,
   input wire         reset_in,
   // fault report
   input wire         abort_in,
   input wire [31:0]  stack_pc_in,
   // stacked pc
   output logic [31:0] stacked_out
);
   always @(posedge clk_in) begin
      if (reset_in) begin
         stacked_out <= 32'h0;
      end else if (abort_in) begin
         stacked_out <= stack_pc_in;
      end
   end
endmodule
`default_nettype wire

// ---- test/rac_checker_tb.sv ----
// testbench for the region access checker
// assumes rac_defs.vh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "rac_defs.vh"
module rac_checker_tb;
   logic clk_in = 1'b0, reset_in = 1'b1, sr_we_in = 1'b0, sr_re_in = 1'b0;
   logic if_valid_in = 1'b0, if_priv_in = 1'b0, dc_valid_in = 1'b0;
   logic dc_write_in = 1'b0, dc_priv_in = 1'b0;
   logic [4:0]  sr_addr_in = 5'h00;
   logic [31:0] sr_wdata_in = 32'h0, if_addr_in = 32'h0;
   logic [31:0] dc_addr_in = 32'h0, dc_pc_in = 32'h0;
   wire [31:0]  sr_rdata_out, stack_pc_out, stacked;
   wire if_done_out, if_prot_out, if_miss_out, dc_done_out, dc_prot_out;
   wire dc_miss_out, multi_hit_out, abort_out;
   int errors = 0, n_tests = 0, c, p, k;
   // rights per code: priv rwx, unpriv rwx
   localparam logic [5:0] RT [0:15] = '{6'h20, 6'h28, 6'h30, 6'h38, 6'h24,
      6'h2d, 6'h36, 6'h3f, 6'h34, 6'h35, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00,
      6'h00};
   // subregion select pattern for region 0
   localparam logic [15:0] SUB_SEL = 16'ha0f5;
   rac_checker dut_u (.clk_in, .reset_in, .sr_we_in, .sr_re_in, .sr_addr_in,
      .sr_wdata_in, .sr_rdata_out, .if_valid_in, .if_addr_in, .if_priv_in,
      .if_done_out, .if_prot_out, .if_miss_out, .dc_valid_in, .dc_addr_in,
      .dc_write_in, .dc_priv_in, .dc_pc_in, .dc_done_out, .dc_prot_out,
      .dc_miss_out, .multi_hit_out, .abort_out, .stack_pc_out);
   rac_core_model core_u (.clk_in(clk_in), .reset_in(reset_in),
      .abort_in(abort_out), .stack_pc_in(stack_pc_out), .stacked_out(stacked));
   always #10 clk_in = ~clk_in;
   // ==========================================================
   // tasks
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      sr_we_in = 1'b1; sr_addr_in = a; sr_wdata_in = d;
      @(negedge clk_in) sr_we_in = 1'b0;
      @(negedge clk_in);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      sr_re_in = 1'b1; sr_addr_in = a;
      @(negedge clk_in) sr_re_in = 1'b0;
      chk("rdata", sr_rdata_out, e);
      @(negedge clk_in);
   endtask
   task automatic acc(input logic s, input logic [31:0] a, input logic w,
      pv, input logic [31:0] pc, input logic ep, em, eu);
      if (s) begin
         dc_valid_in = 1'b1; dc_addr_in = a; dc_write_in = w;
         dc_priv_in = pv; dc_pc_in = pc;
      end else begin
         if_valid_in = 1'b1; if_addr_in = a; if_priv_in = pv;
      end
      @(negedge clk_in);
      chk("done", s ? dc_done_out : if_done_out, 1'b1);
      chk("prot", s ? dc_prot_out : if_prot_out, ep);
      chk("miss", s ? dc_miss_out : if_miss_out, em);
      chk("multi", multi_hit_out, eu);
      chk("abort", abort_out, ep | em | eu);
      if_valid_in = 1'b0; dc_valid_in = 1'b0;
      @(negedge clk_in);
      if (ep | em | eu) chk("stack", stacked, s ? pc : a);
   endtask
   task automatic test_done;
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ==========================================================
   // tests
   initial begin
      repeat (20000) @(posedge clk_in);
      errors++;
      test_done;
   end
   initial begin
      repeat (16) @(negedge clk_in);
      reset_in = 1'b0;
      rd(`RAC_IDX_PERM_A, 32'h0);
      rd(`RAC_IDX_PERM_B, 32'h0);
      rd(`RAC_IDX_CTRL, 32'h0);
      rd(`RAC_IDX_ADDR0, 32'h0);
      rd(5'h1f, 32'h0);
      acc(0, 32'h0002_0000, 0, 1, 32'h0, 0, 0, 0);
      wr(`RAC_IDX_ADDR0, 32'h0001_001b);
      wr(`RAC_IDX_SEL0, {16'h0000, SUB_SEL});
      rd(`RAC_IDX_ADDR0, 32'h0001_001b);
      rd(`RAC_IDX_SEL0, {16'h0000, SUB_SEL});
      wr(`RAC_IDX_PERM_B, 32'h0000_000a);
      wr(`RAC_IDX_CTRL, 32'h0000_0001);
      for (c = 0; c < 16; c++) begin
         wr(`RAC_IDX_PERM_A, {28'h0, c[3:0]});
         for (p = 0; p < 2; p++) begin
            for (k = 0; k < 3; k++) begin
               acc(k != 0, 32'h0001_0400, k == 1, p[0], 32'h4000 + c,
                  !RT[c][p * 3 + k], 0, 0);
            end
         end
      end
      wr(`RAC_IDX_PERM_A, 32'h0000_0007);
      for (k = 0; k < 16; k++) begin
         acc(1, 32'h0001_0000 + k * 32'h400, 0, 0, 32'h5000 + k,
            SUB_SEL[k], 0, 0);
      end
      acc(0, 32'h0001_3ffc, 0, 1, 32'h0, 1, 0, 0);
      acc(0, 32'h0001_4000, 0, 1, 32'h0, 0, 1, 0);
      acc(1, 32'h0000_fffc, 1, 1, 32'h0000_1234, 0, 1, 0);
      wr(`RAC_IDX_ADDR0 + 5'h01, 32'h0001_0017);
      acc(1, 32'h0001_0400, 0, 0, 32'h0000_2468, 0, 0, 1);
      wr(`RAC_IDX_ADDR0 + 5'h01, 32'h0001_0016);
      acc(1, 32'h0001_0400, 0, 0, 32'h0000_2468, 0, 0, 0);
      // region 1 spans the whole space, field 1 of register a is code 0
      wr(`RAC_IDX_ADDR0 + 5'h01, 32'h0000_003f);
      acc(1, 32'h8002_0000, 0, 0, 32'h0000_0777, 1, 0, 0);
      wr(`RAC_IDX_CTRL, 32'h0000_0000);
      acc(1, 32'h0002_0000, 1, 0, 32'h0000_0042, 0, 0, 0);
      test_done;
   end
endmodule
`default_nettype wire
